// >>> hw/ext_ram_pkg.sv
// Shared constants for the external RAM multiplexed bus controller
package ext_ram_pkg;
  // Address slices carried by each latch strobe
  localparam int ADDR_W = 26;
  localparam int LOW_MSB = 9;
  localparam int LOW_LSB = 2;
  localparam int MID_MSB = 17;
  localparam int MID_LSB = 10;
  localparam int HIGH_MSB = 25;
  localparam int HIGH_LSB = 18;
  // Timing: each bus phase lasts this many ns at least
  localparam int CLK_PERIOD_NS = 8;
  localparam int PHASE_NS = 16;
  localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);
  // Reset value of the bus byte lines
  localparam logic [7:0] BUS_RESET = 8'h00;
endpackage

// >>> hw/external_ram_mux_bus.sv
// External byte-wide RAM controller over a multiplexed address/data bus
`timescale 1ns/1ps
module external_ram_mux_bus
  import ext_ram_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // Processor side
  input wire logic ext_ram_enable,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  // Console UART routing
  input wire logic console_tx,
  output logic console_rx,
  output logic console_port_a_tx,
  input wire logic console_port_a_rx,
  output logic console_port_b_tx,
  input wire logic console_port_b_rx,
  // External bus pins
  input wire logic [7:0] ext_bus_byte_lines_in,
  output logic [7:0] ext_bus_byte_lines_out,
  output logic ext_bus_byte_lines_oe_n,
  output logic ext_low_address_bit0,
  output logic ext_low_address_bit1,
  output logic addr_latch_strobe_low,
  output logic addr_latch_strobe_mid,
  output logic addr_latch_strobe_high,
  output logic ram_select_n,
  output logic ram_write_strobe_n,
  output logic ram_output_strobe_n
);
  typedef enum {S_IDLE, S_LAT_LOW, S_LAT_MID, S_LAT_HIGH, S_ACCESS, S_DONE} state_t;

  typedef struct packed {
    state_t state;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] bus;
    logic drive;
    logic le_lo;
    logic le_mid;
    logic le_hi;
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic rsp;
    logic [7:0] rdata;
    logic [2:0] rx_sync;
    logic rx_q;
  } st_t;

  st_t st_ff;
  st_t nxt_st;
  logic phase_start;
  logic phase_done;

  // ========================================
  // Phase timing, one instance serves every bus phase
  phase_timer #(.LAST(PHASE_LAST)) phase_timer_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(phase_start),
    .done(phase_done)
  );

  // ========================================
  // Bus sequencer
  always_comb begin
    nxt_st = st_ff;
    phase_start = 1'b0;
    nxt_st.rsp = 1'b0;
    // Console receive pin synchroniser, three stages
    nxt_st.rx_sync = {st_ff.rx_sync[1:0],
      ext_ram_enable ? console_port_b_rx : console_port_a_rx};
    if (st_ff.rx_sync[2] == st_ff.rx_sync[1]) begin
      nxt_st.rx_q = st_ff.rx_sync[2];
    end
    unique case (st_ff.state)
      S_IDLE: begin
        if (req_valid && ext_ram_enable) begin
          nxt_st.wr = req_write;
          nxt_st.addr = req_addr;
          nxt_st.wdata = req_wdata;
          nxt_st.bus = req_addr[LOW_MSB:LOW_LSB];
          nxt_st.drive = 1'b1;
          nxt_st.le_lo = 1'b1;
          nxt_st.state = S_LAT_LOW;
          phase_start = 1'b1;
        end
      end
      S_LAT_LOW: begin
        // Strobe lasts one cycle and the byte stays on: the latch gets hold time
        nxt_st.le_lo = 1'b0;
        if (phase_done) begin
          nxt_st.le_mid = 1'b1;
          nxt_st.bus = st_ff.addr[MID_MSB:MID_LSB];
          nxt_st.state = S_LAT_MID;
          phase_start = 1'b1;
        end
      end
      S_LAT_MID: begin
        nxt_st.le_mid = 1'b0;
        if (phase_done) begin
          // High strobe always pulses, so larger memories work too
          nxt_st.le_hi = 1'b1;
          nxt_st.bus = st_ff.addr[HIGH_MSB:HIGH_LSB];
          nxt_st.state = S_LAT_HIGH;
          phase_start = 1'b1;
        end
      end
      S_LAT_HIGH: begin
        // A one-cycle phase would lose this hold; phases are at least two cycles
        nxt_st.le_hi = 1'b0;
        if (phase_done) begin
          // Strobes are already low, so the latches hold the address at select
          nxt_st.cs_n = 1'b0;
          nxt_st.we_n = ~st_ff.wr;
          nxt_st.oe_n = st_ff.wr;
          nxt_st.drive = st_ff.wr;
          nxt_st.bus = st_ff.wr ? st_ff.wdata : BUS_RESET;
          nxt_st.state = S_ACCESS;
          phase_start = 1'b1;
        end
      end
      S_ACCESS: begin
        if (phase_done) begin
          nxt_st.we_n = 1'b1;
          nxt_st.oe_n = 1'b1;
          if (!st_ff.wr) begin
            nxt_st.rdata = ext_bus_byte_lines_in;
          end
          nxt_st.state = S_DONE;
        end
      end
      S_DONE: begin
        // Select released one cycle after the strobe for data hold
        nxt_st.cs_n = 1'b1;
        nxt_st.drive = 1'b0;
        nxt_st.rsp = 1'b1;
        nxt_st.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{state: S_IDLE, wr: 1'b0, addr: '0, wdata: '0, bus: BUS_RESET,
                 drive: 1'b0, le_lo: 1'b0, le_mid: 1'b0, le_hi: 1'b0,
                 cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rsp: 1'b0, rdata: '0,
                 rx_sync: 3'h7, rx_q: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================
  // Outputs
  assign req_ready = (st_ff.state == S_IDLE) && ext_ram_enable;
  assign rsp_valid = st_ff.rsp;
  assign rsp_rdata = st_ff.rdata;
  assign ext_bus_byte_lines_out = st_ff.bus;
  assign ext_bus_byte_lines_oe_n = ~st_ff.drive;
  assign ext_low_address_bit0 = st_ff.addr[0];
  assign ext_low_address_bit1 = st_ff.addr[1];
  assign addr_latch_strobe_low = st_ff.le_lo;
  assign addr_latch_strobe_mid = st_ff.le_mid;
  assign addr_latch_strobe_high = st_ff.le_hi;
  assign ram_select_n = st_ff.cs_n;
  assign ram_write_strobe_n = st_ff.we_n;
  assign ram_output_strobe_n = st_ff.oe_n;
  // Idle line is high, so the unused port stays quiet
  assign console_port_a_tx = ext_ram_enable ? 1'b1 : console_tx;
  assign console_port_b_tx = ext_ram_enable ? console_tx : 1'b1;
  assign console_rx = st_ff.rx_q;

  // ========================================
  // Checks
  AST_LOW_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
    addr_latch_strobe_low |-> ext_bus_byte_lines_out == st_ff.addr[LOW_MSB:LOW_LSB])
    else $error("Low strobe without low address byte");
  AST_MID_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
    addr_latch_strobe_mid |-> ext_bus_byte_lines_out == st_ff.addr[MID_MSB:MID_LSB])
    else $error("Mid strobe without mid address byte");
  AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (sys_rst)
    addr_latch_strobe_high |-> ext_bus_byte_lines_out == st_ff.addr[HIGH_MSB:HIGH_LSB])
    else $error("High strobe without high address byte");
  AST_STROBE_DRIVEN: assert property (@(posedge clk) disable iff (sys_rst)
    (addr_latch_strobe_low || addr_latch_strobe_mid || addr_latch_strobe_high)
      |-> !ext_bus_byte_lines_oe_n && ram_select_n)
    else $error("Latch strobe while bus not driven");
  // A falling strobe must see the same byte, or the latch may catch the next one
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(addr_latch_strobe_low) || $fell(addr_latch_strobe_mid)
      || $fell(addr_latch_strobe_high))
      |-> $stable(ext_bus_byte_lines_out) && !ext_bus_byte_lines_oe_n)
    else $error("Bus moved as a latch strobe fell");
  AST_STROBE_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(addr_latch_strobe_low) |-> ##1 addr_latch_strobe_mid ##2 addr_latch_strobe_high)
    else $error("Latch strobes out of order");
  AST_READ_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
    !ram_output_strobe_n |-> ext_bus_byte_lines_oe_n && !ram_select_n && ram_write_strobe_n)
    else $error("Read with bus driven or not selected");
  AST_WRITE_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    !ram_write_strobe_n |-> !ext_bus_byte_lines_oe_n && !ram_select_n
      && ext_bus_byte_lines_out == st_ff.wdata)
    else $error("Write strobe without data driven");
  AST_LOW_PINS: assert property (@(posedge clk) disable iff (sys_rst)
    (req_valid && req_ready)
      |=> {ext_low_address_bit1, ext_low_address_bit0} == $past(req_addr[1:0]))
    else $error("Low address pins wrong");
  AST_CONSOLE_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
    ext_ram_enable |-> console_port_a_tx && console_port_b_tx == console_tx)
    else $error("Console not on port b with RAM enabled");
  AST_RSP_AFTER: assert property (@(posedge clk) disable iff (sys_rst)
    (req_valid && req_ready) |-> ##[4:40] rsp_valid)
    else $error("Access did not complete");
  COV_READ: cover property (@(posedge clk) disable iff (sys_rst) rsp_valid && !st_ff.wr);
  COV_WRITE: cover property (@(posedge clk) disable iff (sys_rst) rsp_valid && st_ff.wr);
  COV_BACK2BACK: cover property (@(posedge clk) disable iff (sys_rst)
    rsp_valid ##1 (req_valid && req_ready));
endmodule // external_ram_mux_bus

// >>> hw/phase_timer.sv
// Phase timer: pulses done after a programmable count of cycles
`timescale 1ns/1ps
module phase_timer
  import ext_ram_pkg::*;
#(
  parameter logic [CNT_W-1:0] LAST = PHASE_LAST
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  output logic done
);
  typedef struct packed {
    logic run;
    logic [CNT_W-1:0] cnt;
  } tmr_t;
  tmr_t st_ff;
  tmr_t nxt_st;

  // ========================================
  // Count up one phase
  always_comb begin
    nxt_st = st_ff;
    done = st_ff.run && (st_ff.cnt == LAST);
    if (start) begin
      nxt_st.run = 1'b1;
      nxt_st.cnt = '0;
    end else if (done) begin
      nxt_st.run = 1'b0;
    end else if (st_ff.run) begin
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // phase_timer

// >>> testbench/external_ram_mux_bus_tb.sv
// Testbench for the external RAM multiplexed bus controller
`timescale 1ns/1ps
module external_ram_mux_bus_tb;
  import ext_ram_pkg::*;
  logic clk, sys_rst, en, req_valid, req_ready, req_write, rsp_valid, ctx, crx, atx, arx, btx;
  logic brx, oe_n, a0, a1, le_lo, le_mid, le_hi, cs_n, we_n, ram_oe_n;
  logic [ADDR_W-1:0] req_addr, lat_addr;
  logic [7:0] req_wdata, rsp_rdata, bus_out, drv, bus, rd;
  int err_count = 0, comparisons = 0, cyc = 0;
  // Bus level: the device while it drives, the RAM otherwise
  assign bus = oe_n ? drv : bus_out;
  external_ram_mux_bus external_ram_mux_bus_inst (.clk(clk), .sys_rst(sys_rst),
    .ext_ram_enable(en), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .console_tx(ctx), .console_rx(crx), .console_port_a_tx(atx), .console_port_a_rx(arx),
    .console_port_b_tx(btx), .console_port_b_rx(brx), .ext_bus_byte_lines_in(bus),
    .ext_bus_byte_lines_out(bus_out), .ext_bus_byte_lines_oe_n(oe_n),
    .ext_low_address_bit0(a0), .ext_low_address_bit1(a1), .addr_latch_strobe_low(le_lo),
    .addr_latch_strobe_mid(le_mid), .addr_latch_strobe_high(le_hi), .ram_select_n(cs_n),
    .ram_write_strobe_n(we_n), .ram_output_strobe_n(ram_oe_n));
  ram_latch_model ram_latch_model_inst (.bus(bus), .a0(a0), .a1(a1), .le_lo(le_lo),
    .le_mid(le_mid), .le_hi(le_hi), .cs_n(cs_n), .we_n(we_n), .oe_n(ram_oe_n), .drv(drv),
    .lat_addr(lat_addr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  // ==========================================
  // One access, judged phase by phase at mid-cycle
  task automatic access(input logic wr, input logic [25:0] addr, input logic [7:0] wd);
    int n;
    logic [2:0] stb;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= addr;
    req_wdata <= wd;
    @(negedge clk);
    check(req_ready, 1'b1, "ready when idle");
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
      // Strobe on odd cycles only; its byte stays one more cycle for latch hold
      stb = n[0] ? 3'b001 << (n / 2) : 3'b000;
      if (n <= 6) begin
        check({le_hi, le_mid, le_lo, oe_n}, {stb, 1'b0}, "strobe");
        check(bus_out, 8'(addr >> (2 + 8 * ((n - 1) / 2))), "address byte");
      end
      if (n == 7) begin
        check({cs_n, we_n, ram_oe_n, oe_n}, wr ? 4'b0010 : 4'b0101, "controls");
        check({a1, a0}, addr[1:0], "low bits");
      end
    end while (rsp_valid !== 1'b1 && n < 20);
    check(n, 10, "answer latency");
    check(req_ready, 1'b1, "ready at finish");
    check(lat_addr[25:2], addr[25:2], "latched address");
    rd = rsp_rdata;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    @(negedge clk);
    check({le_hi, le_mid, le_lo, cs_n, we_n, ram_oe_n, oe_n}, 7'h0f, "idle pins");
    check({rsp_valid, crx}, 2'b01, "idle answer");
    $display("t_reset done");
  endtask
  task automatic t_console();
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      en <= e[0];
      req_valid <= 1'b1;
      arx <= e[0];
      brx <= ~e[0];
      ctx <= 1'b0;
      repeat (6) @(negedge clk);
      check({atx, btx}, {e[0], ~e[0]}, "console tx route");
      check(crx, 1'b0, "console rx route");
      if (e == 0) check({req_ready, rsp_valid}, 2'b00, "refused while off");
      @(posedge clk);
      req_valid <= 1'b0;
      ctx <= 1'b1;
      @(negedge clk);
      check({atx, btx}, 2'b11, "console tx follows");
      repeat (12) @(posedge clk);
    end
    $display("t_console done");
  endtask
  task automatic t_rw();
    logic [25:0] ad [3] = '{26'h3ffffff, 26'h0000001, 26'h2a5c3a6};
    for (int i = 0; i < 3; i++) access(1'b1, ad[i], 8'h3c + 8'(i * 8'h51));
    for (int i = 0; i < 3; i++) begin
      access(1'b0, ad[i], 8'h00);
      check(rd, 8'h3c + 8'(i * 8'h51), "read back");
    end
    $display("t_rw done");
  endtask
  initial begin
    sys_rst = 1'b1;
    {en, req_valid, req_write, ctx, arx, brx} = 6'h0f;
    req_addr = '0;
    req_wdata = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_console();
    t_rw();
    close_out();
  end
endmodule // external_ram_mux_bus_tb

// >>> testbench/ram_latch_model.sv
// Partner model: byte-wide RAM behind three transparent address latches
`timescale 1ns/1ps
module ram_latch_model (
  input wire logic [7:0] bus,
  input wire logic a0,
  input wire logic a1,
  input wire logic le_lo,
  input wire logic le_mid,
  input wire logic le_hi,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [7:0] drv,
  output logic [25:0] lat_addr
);
  logic [7:0] lo, md, hi, rd;
  logic [7:0] mem [int];
  // Latches follow the bus while their strobe is high
  always @* if (le_lo) lo = bus;
  always @* if (le_mid) md = bus;
  // A large memory wires the high latch; a small one could leave it off
  always @* if (le_hi) hi = bus;
  assign lat_addr = {hi, md, lo, a1, a0};
  // Write lands when the write strobe ends under chip select
  always @(posedge we_n) if (!cs_n) mem[lat_addr] = bus;
  // Released bus shows the inverse so a stale value never passes
  always @(lat_addr or cs_n or oe_n or we_n) begin
    rd = mem.exists(lat_addr) ? mem[lat_addr] : 8'h5a;
    drv = (!cs_n && !oe_n) ? rd : ~rd;
  end
endmodule // ram_latch_model
